// *** src/serial_int_host.sv ***
// host end of the shared serial interrupt line: frames, decode and interrupt outputs
// Function
// - after the last data frame the host drives the line low 2 or 3 clocks
// - stop width comes from a software-set configuration input
// - a 2-clock stop puts the link in quiet mode; peripherals may start
// - a 3-clock stop puts the link in continuous mode; only host starts
// - slots 1, 9 and 14 are ignored and never change internal levels
// - pci slots a-d are anded with the wired pci inputs
// - 21 slots in fixed order, slot n sampled 3n-1 clocks past start
// - low in slot 3 raises system management interrupt and its status flag
// - request in slot 17 acts as isa i/o channel check going active
// - irq1 and irq12 enter ahead of the keyboard port latch
// - irq14 and irq15 serial slots never reach gpio interrupt logic
// - irq0 comes only from internal timer counter 0
// - every data frame is sample, recovery and turnaround of one clock
// - low means no request on isa slots, a request on the others
// - continuous start frame is 4, 6 or 8 clocks low by configuration
// - quiet start: host holds low one clock fewer after a peripheral
`include "serial_int_regs.svh"
module serial_int_host (
    // clocks and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic link_clk_i,
    // configuration
    input wire logic stop_wide_i,
    input wire logic [1:0] start_sel_i,
    // shared serial interrupt line
    input wire logic serial_int_line_i,
    output logic serial_int_line_o,
    output logic serial_int_line_oe_o,
    // internal sources
    input wire logic timer_cnt0_irq_i,
    input wire logic rtc_irq_i,
    input wire logic pci_wired_a_n_i,
    input wire logic pci_wired_b_n_i,
    input wire logic pci_wired_c_n_i,
    input wire logic pci_wired_d_n_i,
    input wire logic mgmt_flag_clr_i,
    // decoded interrupts
    output logic [15:0] isa_irq_o,
    output logic sys_mgmt_int_n_o,
    output logic serial_mgmt_int_flag_o,
    output logic io_channel_check_n_o,
    output logic pci_irq_line_a_n_o,
    output logic pci_irq_line_b_n_o,
    output logic pci_irq_line_c_n_o,
    output logic pci_irq_line_d_n_o
);
    import serial_int_pkg::*;

    function automatic logic [6:0] start_len(input logic [1:0] sel);
        case (sel)
            2'b00: start_len = `START_LEN_4;
            2'b01: start_len = `START_LEN_6;
            default: start_len = `START_LEN_8;
        endcase
    endfunction

    function automatic logic is_sample(input logic [6:0] cnt);
        logic [6:0] c1;
        c1 = cnt + 7'h01;
        is_sample = (cnt >= `FIRST_SAMPLE_CNT) && (cnt <= `LAST_SAMPLE_CNT) && (c1 % 7'h03 == 7'h00);
    endfunction

    // ---------------- link domain ----------------
    logic lrst1_r;
    logic link_rst_n_r;
    logic [2:0] cfg_s;
    link_state_t state_r;
    link_state_t state_nxt;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic cont_r;
    logic drv_lo_nxt;
    logic drv_hi_nxt;
    logic smp;
    logic pub;
    slot_idx_t smp_idx;
    slot_vec_t pub_vec;
    logic pub_tgl;

    // reset asserts at once but releases on a link edge
    always_ff @(posedge link_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lrst1_r <= 1'b0;
            link_rst_n_r <= 1'b0;
        end else begin
            lrst1_r <= 1'b1;
            link_rst_n_r <= lrst1_r;
        end
    end

    level_sync3 #(.W(3)) cfg_sync (
        .clk_i(link_clk_i),
        .rst_n_i(link_rst_n_r),
        .d_i({stop_wide_i, start_sel_i}),
        .q_o(cfg_s)
    );

    // the line itself is synchronous to the link clock and is read raw
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (cont_r) begin
                    state_nxt = ST_START;
                    cnt_nxt = start_len(cfg_s[1:0]) - 7'h01;
                end else if (!serial_int_line_i) begin
                    state_nxt = ST_START;
                    cnt_nxt = start_len(cfg_s[1:0]) - 7'h02;
                end
            end
            ST_START: begin
                if (cnt_r == 7'h00) begin
                    state_nxt = ST_DATA;
                    cnt_nxt = 7'h00;
                end else begin
                    cnt_nxt = cnt_r - 7'h01;
                end
            end
            ST_DATA: begin
                if (cnt_r == `DATA_LAST_CNT) begin
                    state_nxt = ST_STOP;
                    cnt_nxt = (cfg_s[2] ? `STOP_WIDE_LEN : `STOP_NARROW_LEN) - 7'h01;
                end else begin
                    cnt_nxt = cnt_r + 7'h01;
                end
            end
            ST_STOP: begin
                if (cnt_r == 7'h00) begin
                    state_nxt = ST_STOP_HI;
                end else begin
                    cnt_nxt = cnt_r - 7'h01;
                end
            end
            ST_STOP_HI: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk_i or negedge link_rst_n_r) begin
        if (!link_rst_n_r) begin
            state_r <= ST_IDLE;
            cnt_r <= 7'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // mode for the next start is fixed by the stop width chosen here
    always_ff @(posedge link_clk_i or negedge link_rst_n_r) begin
        if (!link_rst_n_r) begin
            cont_r <= 1'b1;
        end else if (state_r == ST_DATA && cnt_r == `DATA_LAST_CNT) begin
            cont_r <= cfg_s[2];
        end
    end

    // host drives only start, its recovery, stop and the closing high clock
    assign drv_lo_nxt = (state_nxt == ST_START) || (state_nxt == ST_STOP);
    assign drv_hi_nxt = (state_nxt == ST_DATA && cnt_nxt == 7'h00) || (state_nxt == ST_STOP_HI);

    always_ff @(posedge link_clk_i or negedge link_rst_n_r) begin
        if (!link_rst_n_r) begin
            serial_int_line_o <= 1'b1;
            serial_int_line_oe_o <= 1'b0;
        end else begin
            serial_int_line_o <= drv_hi_nxt;
            serial_int_line_oe_o <= drv_lo_nxt | drv_hi_nxt;
        end
    end

    // recovery and turnaround clocks are skipped; only sample clocks store
    assign smp = (state_r == ST_DATA) && is_sample(cnt_r);
    assign smp_idx = 5'((cnt_r + 7'h01) / 7'h03);
    assign pub = (state_r == ST_DATA) && (cnt_r == `DATA_LAST_CNT);

    slot_store store (
        .clk_i(link_clk_i),
        .rst_n_i(link_rst_n_r),
        .smp_i(smp),
        .idx_i(smp_idx),
        .bit_i(serial_int_line_i),
        .pub_i(pub),
        .pub_vec_o(pub_vec),
        .pub_tgl_o(pub_tgl)
    );

    // ---------------- core domain ----------------
    logic tgl_s;
    logic tgl_seen_r;
    logic new_frame;
    slot_vec_t slot_r;

    level_sync3 #(.W(1)) tgl_sync (
        .clk_i(core_clk_i),
        .rst_n_i(reset_n_i),
        .d_i(pub_tgl),
        .q_o(tgl_s)
    );

    assign new_frame = tgl_s ^ tgl_seen_r;

    // snapshot is held for a full cycle of frames, far longer than the toggle delay
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tgl_seen_r <= 1'b0;
            slot_r <= `SLOT_RESET_VEC;
        end else begin
            tgl_seen_r <= tgl_s;
            if (new_frame) begin
                slot_r <= pub_vec;
            end
        end
    end

    // high sample is an isa request; slots 1, 9, 14 are never read
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            isa_irq_o <= 16'h0000;
        end else begin
            isa_irq_o[0] <= timer_cnt0_irq_i;
            isa_irq_o[1] <= slot_r[`SLOT_IRQ1];
            isa_irq_o[2] <= 1'b0;
            isa_irq_o[7:3] <= slot_r[8:4];
            isa_irq_o[8] <= rtc_irq_i;
            isa_irq_o[11:9] <= slot_r[12:10];
            isa_irq_o[12] <= slot_r[`SLOT_IRQ12];
            isa_irq_o[13] <= 1'b0;
            isa_irq_o[15:14] <= slot_r[16:15];
        end
    end

    // low sample is a request on these slots and drives the active-low lines
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys_mgmt_int_n_o <= 1'b1;
            io_channel_check_n_o <= 1'b1;
        end else begin
            sys_mgmt_int_n_o <= slot_r[`SLOT_MGMT];
            io_channel_check_n_o <= slot_r[`SLOT_IOCHK];
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pci_irq_line_a_n_o <= 1'b1;
            pci_irq_line_b_n_o <= 1'b1;
            pci_irq_line_c_n_o <= 1'b1;
            pci_irq_line_d_n_o <= 1'b1;
        end else begin
            pci_irq_line_a_n_o <= slot_r[`SLOT_PCI_A] & pci_wired_a_n_i;
            pci_irq_line_b_n_o <= slot_r[`SLOT_PCI_B] & pci_wired_b_n_i;
            pci_irq_line_c_n_o <= slot_r[`SLOT_PCI_C] & pci_wired_c_n_i;
            pci_irq_line_d_n_o <= slot_r[`SLOT_PCI_D] & pci_wired_d_n_i;
        end
    end

    // a new request wins over a clear in the same cycle
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            serial_mgmt_int_flag_o <= 1'b0;
        end else if (new_frame && !pub_vec[`SLOT_MGMT]) begin
            serial_mgmt_int_flag_o <= 1'b1;
        end else if (mgmt_flag_clr_i) begin
            serial_mgmt_int_flag_o <= 1'b0;
        end
    end

    // ---------------- checks ----------------
    logic drv_lo;
    logic drv_hi;
    logic at_end;
    assign drv_lo = serial_int_line_oe_o & ~serial_int_line_o;
    assign drv_hi = serial_int_line_oe_o & serial_int_line_o;
    assign at_end = (state_r == ST_DATA) && (cnt_r == `DATA_LAST_CNT);

    a_stop_wide_len: assert property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r)
        at_end && cfg_s[2] |=> drv_lo [*3] ##1 drv_hi ##1 !serial_int_line_oe_o)
        else $error("wide stop frame not three low clocks");
    a_stop_narrow_len: assert property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r)
        at_end && !cfg_s[2] |=> drv_lo [*2] ##1 drv_hi ##1 !serial_int_line_oe_o)
        else $error("narrow stop frame not two low clocks");
    a_quiet_mode_next: assert property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r)
        at_end && !cfg_s[2] |=> !cont_r [*4])
        else $error("narrow stop did not select quiet mode");
    a_cont_mode_next: assert property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r)
        at_end && cfg_s[2] |=> ##4 (cont_r && state_r == ST_IDLE) ##1 drv_lo)
        else $error("wide stop did not lead to host start");
    a_frame_span: assert property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r)
        state_r == ST_START && cnt_r == 7'h00 |=> drv_hi ##65 (state_r == ST_STOP))
        else $error("data frames do not span 65 clocks");
    a_data_released: assert property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r)
        state_r == ST_DATA && cnt_r != 7'h00 |-> !serial_int_line_oe_o)
        else $error("host drove line inside data frames");
    a_start_cont_width: assert property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r)
        state_r == ST_IDLE && cont_r && cfg_s[1:0] == 2'b00 |=> drv_lo [*4] ##1 drv_hi)
        else $error("continuous start not four clocks");
    a_start_quiet_width: assert property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r)
        state_r == ST_IDLE && !cont_r && !serial_int_line_i && cfg_s[1:0] == 2'b01
        |=> drv_lo [*5] ##1 drv_hi)
        else $error("quiet start not one clock short of six");
    a_stop_release: assert property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r)
        state_r == ST_STOP_HI |-> drv_hi ##1 !serial_int_line_oe_o)
        else $error("line not released after stop high clock");
    a_timer_irq0: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        1'b1 |=> isa_irq_o[0] == $past(timer_cnt0_irq_i))
        else $error("irq0 not from internal timer");
    a_ignored_slots: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        1'b1 |=> isa_irq_o[8] == $past(rtc_irq_i) && !isa_irq_o[13])
        else $error("ignored slot changed an internal level");
    a_pci_and: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        1'b1 |=> pci_irq_line_a_n_o == ($past(slot_r[`SLOT_PCI_A]) & $past(pci_wired_a_n_i)))
        else $error("pci line a not the and of both sources");
    a_mgmt_flag: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        new_frame && !pub_vec[`SLOT_MGMT] |=> serial_mgmt_int_flag_o ##1 !sys_mgmt_int_n_o)
        else $error("mgmt request missed flag or interrupt");
    a_iochk: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        new_frame && !pub_vec[`SLOT_IOCHK] |=> ##1 !io_channel_check_n_o)
        else $error("channel check request not raised");

    c_quiet_start: cover property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r)
        state_r == ST_IDLE && !cont_r && !serial_int_line_i);
    c_wide_stop: cover property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r) at_end && cfg_s[2]);
    c_narrow_stop: cover property (
        @(posedge link_clk_i) disable iff (!link_rst_n_r) at_end && !cfg_s[2]);
    c_mgmt_request: cover property (
        @(posedge core_clk_i) disable iff (!reset_n_i) new_frame && !pub_vec[`SLOT_MGMT]);
endmodule // serial_int_host

// *** src/serial_int_regs.svh ***
// constants for the serial interrupt host frame engine
`ifndef SERIAL_INT_REGS_SVH
`define SERIAL_INT_REGS_SVH

// frame timing in link clocks
`define START_LEN_4 7'h04
`define START_LEN_6 7'h06
`define START_LEN_8 7'h08
`define STOP_NARROW_LEN 7'h02
`define STOP_WIDE_LEN 7'h03
`define FIRST_SAMPLE_CNT 7'h02
`define LAST_SAMPLE_CNT 7'h3e
`define DATA_LAST_CNT 7'h40

// slot numbers in the serial stream
`define SLOT_IRQ1 5'h02
`define SLOT_MGMT 5'h03
`define SLOT_IRQ12 5'h0d
`define SLOT_IOCHK 5'h11
`define SLOT_PCI_A 5'h12
`define SLOT_PCI_B 5'h13
`define SLOT_PCI_C 5'h14
`define SLOT_PCI_D 5'h15

// idle view of all slots: isa quiet, active-low requests released
`define SLOT_RESET_VEC 21'h1f_0004

`endif

// *** src/serial_int_pkg.sv ***
// types for the serial interrupt host frame engine
package serial_int_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_DATA = 3'b011,
        ST_STOP = 3'b010,
        ST_STOP_HI = 3'b110
    } link_state_t;
    typedef logic [21:1] slot_vec_t;
    typedef logic [4:0] slot_idx_t;
endpackage

// *** src/level_sync3.sv ***
// three-stage synchroniser whose output moves only when stages two and three agree
module level_sync3 #(
    parameter int W = 1
) (
    // clock and reset of the receiving domain
    input wire logic clk_i,
    input wire logic rst_n_i,
    // level in and filtered level out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a bit only follows once both late stages hold the same value
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= '0;
        end else begin
            q_o <= (s2_r & s3_r) | (q_o & (s2_r | s3_r));
        end
    end
endmodule // level_sync3

// *** src/slot_store.sv ***
// per-slot capture flops on the link clock and the snapshot handed to the core
`include "serial_int_regs.svh"
module slot_store
    import serial_int_pkg::*;
(
    // link clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // one sample into one slot
    input wire logic smp_i,
    input wire serial_int_pkg::slot_idx_t idx_i,
    input wire logic bit_i,
    // snapshot at end of data frames
    input wire logic pub_i,
    output serial_int_pkg::slot_vec_t pub_vec_o,
    output logic pub_tgl_o
);
    slot_vec_t cap_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_r <= `SLOT_RESET_VEC;
        end else if (smp_i) begin
            cap_r[idx_i] <= bit_i;
        end
    end

    // snapshot stays still for a whole cycle, so the core may read it after the toggle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pub_vec_o <= `SLOT_RESET_VEC;
            pub_tgl_o <= 1'b0;
        end else if (pub_i) begin
            pub_vec_o <= cap_r;
            pub_tgl_o <= ~pub_tgl_o;
        end
    end
endmodule // slot_store

// *** verif/serial_periph_model.sv ***
// behavioural peripheral on the shared serial interrupt line
module serial_periph_model (
    // link clock and reset
    input wire logic link_clk_i,
    input wire logic reset_n_i,
    // resolved line level and slot requests
    input wire logic line_i,
    input wire logic [21:1] low_vec_i,
    // pull-down and observations
    output logic drive_low_o,
    output logic [3:0] start_len_o,
    output logic [3:0] stop_len_o,
    output logic quiet_o,
    output int frame_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] cnt_r;
    logic active_r;
    logic kick_r;
    logic [3:0] lo_run_r;
    logic [3:0] stop_run_r;
    logic [2:0] idle_r;
    logic [21:1] vec_r;
    logic [4:0] slot;
    assign slot = 5'((cnt_r + 7'h01) / 7'h03);
    // pull low only in the sample clock or the one-clock start kick, recovery is left to the pull-up
    assign drive_low_o = kick_r || (active_r && (cnt_r % 7'h03 == 7'h02) &&
        (cnt_r <= 7'h3e) && vec_r[slot]);
    always_ff @(posedge link_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= 7'h00;
            active_r <= 1'b0;
            kick_r <= 1'b0;
            lo_run_r <= 4'h0;
            stop_run_r <= 4'h0;
            idle_r <= 3'h7;
            vec_r <= '0;
            start_len_o <= 4'h0;
            stop_len_o <= 4'h0;
            quiet_o <= 1'b0;
            frame_cnt_o <= 0;
        end else begin
            lo_run_r <= line_i ? 4'h0 : lo_run_r + 4'h1;
            kick_r <= 1'b0;
            if (!active_r) begin
                idle_r <= (idle_r == 3'h7) ? idle_r : idle_r + 3'h1;
                // frames are counted from the rise that ends the start frame
                if (line_i && lo_run_r >= 4'h4) begin
                    active_r <= 1'b1;
                    cnt_r <= 7'h01;
                    start_len_o <= lo_run_r;
                    vec_r <= low_vec_i;
                    stop_run_r <= 4'h0;
                end else if (quiet_o && line_i && idle_r == 3'h3) begin
                    kick_r <= 1'b1;
                end
            end else begin
                cnt_r <= cnt_r + 7'h01;
                // the line is seen one clock after it is driven, so stop lows land at 65..67
                if (cnt_r >= 7'h41 && cnt_r <= 7'h43 && !line_i) begin
                    stop_run_r <= stop_run_r + 4'h1;
                end
                if (cnt_r == 7'h44) begin
                    active_r <= 1'b0;
                    idle_r <= 3'h0;
                    stop_len_o <= stop_run_r;
                    quiet_o <= (stop_run_r == 4'h2);
                    frame_cnt_o <= frame_cnt_o + 1;
                end
            end
        end
    end
endmodule // serial_periph_model

// *** verif/tb_serial_int_host.sv ***
// self-checking bench for the serial interrupt host
module tb_serial_int_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic stop_wide_i = 1'b1;
    logic [1:0] start_sel_i = 2'b00;
    logic timer_cnt0_irq_i = 1'b0;
    logic rtc_irq_i = 1'b0;
    logic [3:0] wired_n = 4'hf;
    logic mgmt_flag_clr_i = 1'b0;
    logic [21:1] low_vec = '0;
    logic line_o, line_oe, drive_low, line, quiet;
    logic [15:0] isa_irq;
    logic mgmt_n, flag, iochk_n;
    logic [3:0] pci_n, start_len, stop_len;
    int frame_cnt;
    int miscompares = 0;
    int checks = 0;
    // pulled-up wire: low whenever any party pulls it low
    assign line = ((line_oe && !line_o) || drive_low) ? 1'b0 : 1'b1;
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial begin
        #7;
        forever #24 link_clk_i = ~link_clk_i;
    end
    serial_int_host u_serial_int_host (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk_i),
        .stop_wide_i(stop_wide_i), .start_sel_i(start_sel_i),
        .serial_int_line_i(line), .serial_int_line_o(line_o),
        .serial_int_line_oe_o(line_oe), .timer_cnt0_irq_i(timer_cnt0_irq_i),
        .rtc_irq_i(rtc_irq_i), .pci_wired_a_n_i(wired_n[0]), .pci_wired_b_n_i(wired_n[1]),
        .pci_wired_c_n_i(wired_n[2]), .pci_wired_d_n_i(wired_n[3]),
        .mgmt_flag_clr_i(mgmt_flag_clr_i), .isa_irq_o(isa_irq), .sys_mgmt_int_n_o(mgmt_n),
        .serial_mgmt_int_flag_o(flag), .io_channel_check_n_o(iochk_n),
        .pci_irq_line_a_n_o(pci_n[0]), .pci_irq_line_b_n_o(pci_n[1]),
        .pci_irq_line_c_n_o(pci_n[2]), .pci_irq_line_d_n_o(pci_n[3])
    );
    serial_periph_model u_serial_periph_model (
        .link_clk_i(link_clk_i), .reset_n_i(reset_n_i), .line_i(line),
        .low_vec_i(low_vec), .drive_low_o(drive_low), .start_len_o(start_len),
        .stop_len_o(stop_len), .quiet_o(quiet), .frame_cnt_o(frame_cnt)
    );
    // isa slots carry the line level itself; timer, rtc and reserved never come from it
    function automatic logic [15:0] exp_isa(input logic [21:1] lv, input logic t,
                                            input logic r);
        logic [15:0] e;
        e = 16'h0000;
        for (int k = 1; k < 16; k++) begin
            e[k] = lv[k+1];
        end
        e[0] = t;
        e[2] = 1'b0;
        e[8] = r;
        e[13] = 1'b0;
        return e;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // bounded wait for the model to see one more complete cycle
    task automatic wait_frame();
        int n0;
        int t;
        n0 = frame_cnt;
        t = 0;
        while (frame_cnt == n0 && t < 200) begin
            @(negedge core_clk_i);
            t++;
        end
        if (t >= 200) begin
            miscompares++;
            $display("[ERR] %0t no frame end", $time);
        end
    endtask
    initial begin
        #1_000_000;
        miscompares++;
        end_sim();
    end
    initial begin
        logic [21:1] corner [4];
        logic [21:1] prev;
        logic [21:1] lv;
        logic [3:0] exp_start;
        corner = '{21'h00_0000, 21'h1f_ffff, 21'h00_2101, 21'h00_0004};
        prev = '0;
        void'($urandom(32'h984d_6201));
        repeat (16) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        wait_frame();
        repeat (10) @(negedge core_clk_i);
        for (int i = 0; i < 24; i++) begin
            // frame in flight keeps the old start width and requests but takes the new stop width; the one after uses all new
            low_vec = (i < 4) ? corner[i] : 21'($urandom);
            start_sel_i = (i < 8) ? i[1:0] : 2'($urandom);
            stop_wide_i = (i < 8) ? i[2] : 1'($urandom);
            timer_cnt0_irq_i = 1'($urandom);
            rtc_irq_i = 1'($urandom);
            wired_n = 4'($urandom);
            mgmt_flag_clr_i = 1'b1;
            @(negedge core_clk_i);
            mgmt_flag_clr_i = 1'b0;
            wait_frame();
            wait_frame();
            repeat (10) @(negedge core_clk_i);
            lv = ~low_vec;
            exp_start = (start_sel_i == 2'b00) ? 4'h4 : (start_sel_i == 2'b01) ? 4'h6 : 4'h8;
            check(isa_irq, exp_isa(lv, timer_cnt0_irq_i, rtc_irq_i));
            check(16'(mgmt_n), 16'(lv[3]));
            check(16'(flag), 16'(low_vec[3] | prev[3]));
            check(16'(iochk_n), 16'(lv[17]));
            check(16'(pci_n), 16'(lv[21:18] & wired_n));
            check(16'(stop_len), stop_wide_i ? 16'h0003 : 16'h0002);
            check(16'(quiet), 16'(!stop_wide_i));
            check(16'(start_len), 16'(exp_start));
            prev = low_vec;
        end
        end_sim();
    end
endmodule // tb_serial_int_host
